// File: inc/mis_pkg.sv
// Constants of the MAC interrupt status summary block: offsets, fields, resets.
// Assumes one 40 MHz system clock and an AHB-Lite master issuing word accesses.
// Function
// - Tx summary ORs enabled status bits 17-24
// - Tx interrupt needs summary and master enable
// - Clearing tx status bits drops tx summary
// - Control frame sets bit 14, full duplex only
// - Enabled control frame raises rx summary; W1C
// - Rx DMA error response while receiving sets bit 11
// - Enabled rx bus error raises rx summary; W1C
// - Every latched status bit clears by writing 1
package mis_pkg;

	// Register byte offsets inside the decoded window
	localparam int unsigned    DEC_W       = 12;            // Decoded address bits
	localparam logic [11:0]    STATUS_OFS  = 12'h000;       // mac_interrupt_status
	localparam logic [11:0]    ENABLE_OFS  = 12'h004;       // mac_interrupt_enable
	localparam logic [11:0]    CONTROL_OFS = 12'h008;       // Mode control

	// Reset values
	localparam logic [31:0]    STATUS_RST  = 32'h0000_0000; // All status clear
	localparam logic [31:0]    ENABLE_RST  = 32'h0000_0000; // All sources masked
	localparam logic [31:0]    CONTROL_RST = 32'h0000_0000; // Half duplex

	// Field positions in status and enable registers
	localparam int unsigned    TX_LO       = 17;            // Lowest tx source bit
	localparam int unsigned    TX_CNT      = 8;             // Tx sources 17..24
	localparam int unsigned    TX_SUM_BIT  = 16;            // Tx summary / master enable
	localparam int unsigned    FCF_BIT     = 14;            // control_frame_received
	localparam int unsigned    RXBE_BIT    = 11;            // rx_bus_error
	localparam int unsigned    RX_SUM_BIT  = 0;             // Rx summary / master enable
	localparam int unsigned    FDX_BIT     = 0;             // Full duplex in control

	// Sticky source bank layout: tx sources, then the two rx sources
	localparam int unsigned    NUM_SRC     = 10;            // Latched sources held
	localparam int unsigned    SRC_FCF     = 8;             // Bank index of bit 14
	localparam int unsigned    SRC_RXBE    = 9;             // Bank index of bit 11

	// AHB-Lite encodings
	localparam logic [2:0]     HSIZE_WORD  = 3'h2;          // 32-bit transfer
	localparam logic           HRESP_OKAY  = 1'h0;          // Only response used

	// Data phase tracking, Gray along idle-read-write
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,                                    // No data phase
		ST_READ  = 2'h1,                                    // Read data phase
		ST_WRITE = 2'h3                                     // Write data phase
	} bus_state_type;

endpackage : mis_pkg

// File: rtl/mis_irq_summary.sv
// Summary flags and gated interrupt lines from status and enables.
// Assumes status and enable inputs are the values taking effect at the next edge.
`timescale 1ns/1ps
module mis_irq_summary (
	input  wire logic                       i_clk_sys,   // System clock
	input  wire logic                       i_rst_n,     // Async reset, low
	input  wire logic [mis_pkg::NUM_SRC-1:0] i_status,   // Next latched status
	input  wire logic [mis_pkg::NUM_SRC-1:0] i_src_en,   // Next per-source enables
	input  wire logic                       i_tx_master, // Next tx master enable
	input  wire logic                       i_rx_master, // Next rx master enable
	output logic                            o_tx_sum,    // Tx summary, next value
	output logic                            o_rx_sum,    // Rx summary, next value
	output logic                            o_tx_irq_q,  // Registered tx interrupt
	output logic                            o_rx_irq_q   // Registered rx interrupt
);

	logic [mis_pkg::NUM_SRC-1:0] masked;   // Status gated by enables
	logic                        tx_sum;   // OR of enabled tx sources
	logic                        rx_sum;   // OR of enabled rx sources
	logic                        tx_irq_d; // Next tx line
	logic                        rx_irq_d; // Next rx line
	logic                        tx_irq_q; // Tx line flop
	logic                        rx_irq_q; // Rx line flop

	// Summaries are pure logic, so clearing sources drops them at once
	always_comb begin
		masked   = i_status & i_src_en;
		tx_sum   = |masked[mis_pkg::TX_CNT-1:0];
		rx_sum   = masked[mis_pkg::SRC_FCF]
		         | masked[mis_pkg::SRC_RXBE];
		tx_irq_d = tx_sum & i_tx_master;
		rx_irq_d = rx_sum & i_rx_master;
	end

	// Interrupt lines leave through flops
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_irq_q <= 1'h0;
			rx_irq_q <= 1'h0;
		end else begin
			tx_irq_q <= tx_irq_d;
			rx_irq_q <= rx_irq_d;
		end
	end

	assign o_tx_sum   = tx_sum;
	assign o_rx_sum   = rx_sum;
	assign o_tx_irq_q = tx_irq_q;
	assign o_rx_irq_q = rx_irq_q;

endmodule : mis_irq_summary

// File: rtl/mis_irq_top.sv
// Top of the MAC interrupt status summary: AHB-Lite slave, enable and
// control registers, event qualification, status bank and summary.
// Assumes event inputs are one-cycle pulses from MAC logic on i_clk_sys,
// and a single AHB-Lite master whose hready is this slave's hreadyout.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module mis_irq_top (
	// Clock and reset
	input  wire logic        i_clk_sys,          // 40 MHz system clock
	input  wire logic        i_rst_n,            // Async reset, low
	// AHB-Lite slave port
	input  wire logic        i_hsel,             // Slave select
	input  wire logic [31:0] i_haddr,            // Byte address
	input  wire logic [1:0]  i_htrans,           // Transfer type
	input  wire logic        i_hwrite,           // Write when high
	input  wire logic [2:0]  i_hsize,            // Transfer size
	input  wire logic [31:0] i_hwdata,           // Write data
	input  wire logic        i_hready,           // Bus ready in
	output logic      [31:0] o_hrdata,           // Read data
	output logic             o_hreadyout,        // Slave ready
	output logic             o_hresp,            // Response, always OKAY
	// MAC event inputs
	input  wire logic [7:0]  i_tx_status_set,    // Tx source pulses, bits 17..24
	input  wire logic        i_flow_ctrl_frame,  // Flow control frame seen
	input  wire logic        i_rx_dma_err_resp,  // ERROR reply to receive_dma
	input  wire logic        i_rx_receiving,     // Packet reception in progress
	// Interrupt outputs toward the CPU
	output logic             o_tx_irq,           // Transmit interrupt
	output logic             o_rx_irq,           // Receive interrupt
	output logic             o_full_duplex       // Full duplex mode bit
);

	// Register map, word aligned, decoded on address bits [11:2]:
	//   status  : [24:17] tx sources, [16] tx summary, [14] flow
	//             control frame, [11] rx bus error, [0] rx summary
	//   enable  : same positions; [16] and [0] are master enables
	//   control : [0] full duplex, other bits read as zero
	// Summary bits are computed, so writes to them do nothing.
	// Zero wait states: a transfer ends one edge after its address
	// phase; a read right after a write sees the written value
	// because reads sample the next-state values.
	// An event and a write-1 clear at one edge: the event wins, so
	// a pulse is never lost to a clear in the same cycle.

	// Bus tracking state
	mis_pkg::bus_state_type           bus_q;          // Data phase kind
	mis_pkg::bus_state_type           bus_d;          // Next data phase kind
	logic [mis_pkg::DEC_W-1:0]        addr_q;         // Latched offset
	logic [mis_pkg::DEC_W-1:0]        addr_d;         // Next latched offset
	logic [31:0]                      hrdata_q;       // Read data flop
	logic [31:0]                      hrdata_d;       // Next read data
	logic                             hready_q;       // Ready flop
	logic                             hready_d;       // Next ready

	// Software registers
	logic [31:0]                      enable_q;       // mac_interrupt_enable
	logic [31:0]                      enable_d;       // Next enable
	logic [31:0]                      control_q;      // Mode control
	logic [31:0]                      control_d;      // Next control

	// Decode and strobes
	logic                             addr_phase;     // Valid address phase now
	logic                             wr_now;         // Write data phase ends now
	logic                             wr_status;      // Write to status
	logic                             wr_enable;      // Write to enable
	logic                             wr_control;     // Write to control

	// Status bank wiring
	logic [mis_pkg::NUM_SRC-1:0]      src_set;        // Qualified events
	logic [mis_pkg::NUM_SRC-1:0]      src_clr;        // Write-1 clears
	logic [mis_pkg::DEC_W-1:0]        req_ofs;        // Offset of this address phase
	logic                             hresp_q;        // Response flop
	logic                             hresp_d;        // Next response
	logic [mis_pkg::NUM_SRC-1:0]      src_d;          // Status after this edge
	logic [mis_pkg::NUM_SRC-1:0]      src_en_d;       // Enables after this edge
	logic                             tx_sum;         // Tx summary, next value
	logic                             rx_sum;         // Rx summary, next value
	logic                             tx_irq_q;       // Registered tx line
	logic                             rx_irq_q;       // Registered rx line
	logic [31:0]                      status_view;    // Status as read

	// Word offset of the current address phase, low bits forced to zero
	always_comb begin
		req_ofs = {i_haddr[mis_pkg::DEC_W-1:2], 2'h0};
	end

	// An address phase counts only when selected, non-idle and bus ready
	always_comb begin
		addr_phase = i_hsel & i_htrans[1] & i_hready;
		wr_now     = (bus_q == mis_pkg::ST_WRITE);
	end

	// Write strobes from the offset latched in the address phase
	always_comb begin
		wr_status  = wr_now && (addr_q == mis_pkg::STATUS_OFS);
		wr_enable  = wr_now && (addr_q == mis_pkg::ENABLE_OFS);
		wr_control = wr_now && (addr_q == mis_pkg::CONTROL_OFS);
	end

	// Bus tracking: one data phase per accepted transfer, no wait states
	// The state only records which data phase is in flight; it never
	// stalls, so hreadyout stays high in every case item below.
	// The case is kept so that a wait state could slot in later.
	always_comb begin
		bus_d    = mis_pkg::ST_IDLE;
		addr_d   = addr_q;
		hready_d = 1'h1;
		if (addr_phase) begin
			// Only whole-word transfers are expected; others still complete
			addr_d = req_ofs;
			if (i_hwrite) begin
				bus_d = mis_pkg::ST_WRITE;
			end else begin
				bus_d = mis_pkg::ST_READ;
			end
		end
		case (bus_q)
			mis_pkg::ST_IDLE: begin
				hready_d = 1'h1;  // Idle, always ready
			end
			mis_pkg::ST_READ: begin
				hready_d = 1'h1;  // Read data already registered
			end
			mis_pkg::ST_WRITE: begin
				hready_d = 1'h1;  // Write lands at this edge
			end
			default: begin
				hready_d = 1'h1;  // Unused code, recover to ready
			end
		endcase
	end

	// Bus tracking registers
	// Reset leaves the slave ready with no data phase open
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_q    <= mis_pkg::ST_IDLE;
			addr_q   <= '0;
			hready_q <= 1'h1;
		end else begin
			bus_q    <= bus_d;
			addr_q   <= addr_d;
			hready_q <= hready_d;
		end
	end

	// Enable and control registers; writes replace the whole word
	// Enable bits outside the source and master positions are kept
	// but drive nothing
	always_comb begin
		enable_d  = enable_q;
		control_d = control_q;
		if (wr_enable) begin
			enable_d = i_hwdata;
		end
		if (wr_control) begin
			// Only the full duplex bit exists; the rest read as zero
			control_d = 32'h0000_0000;
			control_d[mis_pkg::FDX_BIT] = i_hwdata[mis_pkg::FDX_BIT];
		end
	end

	// Software register flops
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_q  <= mis_pkg::ENABLE_RST;
			control_q <= mis_pkg::CONTROL_RST;
		end else begin
			enable_q  <= enable_d;
			control_q <= control_d;
		end
	end

	// Event qualification into the sticky bank
	always_comb begin
		src_set = '0;
		// Tx events need no qualification here
		src_set[mis_pkg::TX_CNT-1:0] = i_tx_status_set;
		// Flow control frames count only in full duplex
		src_set[mis_pkg::SRC_FCF]  = i_flow_ctrl_frame
		                           & control_q[mis_pkg::FDX_BIT];
		// Error reply to a receive DMA access while receiving
		src_set[mis_pkg::SRC_RXBE] = i_rx_dma_err_resp
		                           & i_rx_receiving;
	end

	// Write-1 clears, taken from the matching status bit positions
	// A clear acts only in the data phase of a status write, while
	// i_hwdata stands; summary positions are no clear targets
	always_comb begin
		src_clr = '0;
		if (wr_status) begin
			src_clr[mis_pkg::TX_CNT-1:0] =
				i_hwdata[mis_pkg::TX_LO +: mis_pkg::TX_CNT];
			src_clr[mis_pkg::SRC_FCF]  = i_hwdata[mis_pkg::FCF_BIT];
			src_clr[mis_pkg::SRC_RXBE] = i_hwdata[mis_pkg::RXBE_BIT];
		end
	end

	// Per-source enables gathered from the enable register
	// Taken from the next enable word, so an enable write and the
	// summary it gates take effect at the same edge
	always_comb begin
		src_en_d = '0;
		src_en_d[mis_pkg::TX_CNT-1:0] = enable_d[mis_pkg::TX_LO +: mis_pkg::TX_CNT];
		src_en_d[mis_pkg::SRC_FCF]    = enable_d[mis_pkg::FCF_BIT];
		src_en_d[mis_pkg::SRC_RXBE]   = enable_d[mis_pkg::RXBE_BIT];
	end

	// Latched status sources
	mis_status_bank u_bank (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_set     (src_set),
		.i_clr     (src_clr),
		.o_bits_q  (),
		.o_bits_d  (src_d)
	);

	// Summaries and interrupt lines from the values after this edge
	// The lines are registered inside; the master enables come
	// straight from the next enable word
	mis_irq_summary u_sum (
		.i_clk_sys   (i_clk_sys),
		.i_rst_n     (i_rst_n),
		.i_status    (src_d),
		.i_src_en    (src_en_d),
		.i_tx_master (enable_d[mis_pkg::TX_SUM_BIT]),
		.i_rx_master (enable_d[mis_pkg::RX_SUM_BIT]),
		.o_tx_sum    (tx_sum),
		.o_rx_sum    (rx_sum),
		.o_tx_irq_q  (tx_irq_q),
		.o_rx_irq_q  (rx_irq_q)
	);

	// Status word as software sees it; summaries are read-only
	// Built from the values after this edge, so a read in the cycle
	// of an event already shows it
	always_comb begin
		status_view = mis_pkg::STATUS_RST;
		status_view[mis_pkg::TX_LO +: mis_pkg::TX_CNT] = src_d[mis_pkg::TX_CNT-1:0];
		status_view[mis_pkg::TX_SUM_BIT] = tx_sum;
		status_view[mis_pkg::FCF_BIT]    = src_d[mis_pkg::SRC_FCF];
		status_view[mis_pkg::RXBE_BIT]   = src_d[mis_pkg::SRC_RXBE];
		status_view[mis_pkg::RX_SUM_BIT] = rx_sum;
	end

	// Read data captured at the end of the address phase, from the
	// values after this edge so a write just before is seen at once
	always_comb begin
		hrdata_d = hrdata_q;
		if (addr_phase && !i_hwrite) begin
			case (req_ofs)
				mis_pkg::STATUS_OFS: begin
					hrdata_d = status_view;
				end
				mis_pkg::ENABLE_OFS: begin
					hrdata_d = enable_d;
				end
				mis_pkg::CONTROL_OFS: begin
					hrdata_d = control_d;
				end
				default: begin
					hrdata_d = 32'h0000_0000;  // Unmapped reads zero
				end
			endcase
		end
	end

	// Read data flop
	// Holds until the next read address phase, as the bus expects
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hrdata_q <= 32'h0000_0000;
		end else begin
			hrdata_q <= hrdata_d;
		end
	end

	// Response: nothing here is ever refused, so it stays OKAY
	always_comb begin
		hresp_d = mis_pkg::HRESP_OKAY;
	end

	// Response flop, OKAY from reset on
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hresp_q <= mis_pkg::HRESP_OKAY;
		end else begin
			hresp_q <= hresp_d;
		end
	end

	// Outputs straight from flops; the response never leaves OKAY
	// The interrupt lines move at the same edge as the status they gate
	assign o_hrdata      = hrdata_q;
	assign o_hreadyout   = hready_q;
	assign o_hresp       = hresp_q;
	assign o_tx_irq      = tx_irq_q;
	assign o_rx_irq      = rx_irq_q;
	assign o_full_duplex = control_q[mis_pkg::FDX_BIT];

endmodule : mis_irq_top

// File: rtl/mis_status_bank.sv
// Bank of latched status bits with write-1-to-clear.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module mis_status_bank (
	input  wire logic                       i_clk_sys, // System clock
	input  wire logic                       i_rst_n,   // Async reset, low
	input  wire logic [mis_pkg::NUM_SRC-1:0] i_set,    // Hardware events
	input  wire logic [mis_pkg::NUM_SRC-1:0] i_clr,    // Software write of 1
	output logic      [mis_pkg::NUM_SRC-1:0] o_bits_q, // Latched status
	output logic      [mis_pkg::NUM_SRC-1:0] o_bits_d  // Value after this edge
);

	logic [mis_pkg::NUM_SRC-1:0] bits_q; // Stored status
	logic [mis_pkg::NUM_SRC-1:0] bits_d; // Next status

	// One sticky bit per source; an event in the clearing cycle wins
	genvar g;
	generate
		for (g = 0; g < mis_pkg::NUM_SRC; g++) begin : g_bit
			always_comb begin
				bits_d[g] = i_set[g] | (bits_q[g] & ~i_clr[g]);
			end
		end
	endgenerate

	// Register the bank
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bits_q <= '0;
		end else begin
			bits_q <= bits_d;
		end
	end

	assign o_bits_q = bits_q;
	assign o_bits_d = bits_d;

endmodule : mis_status_bank

// File: sim/mis_irq_top_checker.sv
// Checker of the interrupt status summary, bound to mis_irq_top.
// Assumes one clock domain and the bus hready tied to the slave's hreadyout.
`timescale 1ns/1ps
module mis_irq_top_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic        i_hready,
	input wire logic [7:0]  i_tx_status_set,
	input wire logic        i_flow_ctrl_frame,
	input wire logic        i_rx_dma_err_resp,
	input wire logic        i_rx_receiving,
	input wire logic [31:0] o_hrdata,
	input wire logic        o_hreadyout,
	input wire logic        o_hresp,
	input wire logic        o_tx_irq,
	input wire logic        o_rx_irq,
	input wire logic        o_full_duplex
);
	logic        wr_ph_q;  // Write data phase under way
	logic        en_wr_q;  // That phase targets the enable register
	logic [31:0] en_q;     // Shadow of the enable register
	logic        wr_q;     // A write phase ended at the last edge
	logic        rd_q;     // A read address phase was taken at the last edge
	logic        tx_why_q; // Some cause for a tx rise at the last edge
	logic        rx_why_q; // Some cause for an rx rise at the last edge
	wire         take_w = i_hsel & i_htrans[1] & i_hready;
	// Helper state: bus phases, enable shadow and interrupt causes
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ph_q  <= 1'h0;
			en_wr_q  <= 1'h0;
			en_q     <= 32'h0000_0000;
			wr_q     <= 1'h0;
			rd_q     <= 1'h0;
			tx_why_q <= 1'h0;
			rx_why_q <= 1'h0;
		end else begin
			wr_ph_q  <= take_w & i_hwrite;
			en_wr_q  <= take_w & i_hwrite & (i_haddr[11:2] == mis_pkg::ENABLE_OFS[11:2]);
			if (en_wr_q) begin
				en_q <= i_hwdata;
			end
			wr_q     <= wr_ph_q;
			rd_q     <= take_w & ~i_hwrite;
			tx_why_q <= (|i_tx_status_set) | wr_ph_q;
			rx_why_q <= (i_flow_ctrl_frame & o_full_duplex) | wr_ph_q
				| (i_rx_dma_err_resp & i_rx_receiving);
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	chk_tx_rise_cause: assert property ($rose(o_tx_irq) |-> tx_why_q)
		else $error("tx interrupt rose without event or write");
	chk_tx_fall_cause: assert property ($fell(o_tx_irq) |-> wr_q)
		else $error("tx interrupt fell without a write");
	chk_tx_enables: assert property (o_tx_irq |-> en_q[16] && (|en_q[24:17]))
		else $error("tx interrupt high while its enables are off");
	chk_rx_rise_cause: assert property ($rose(o_rx_irq) |-> rx_why_q)
		else $error("rx interrupt rose without qualified event or write");
	chk_rx_fall_cause: assert property ($fell(o_rx_irq) |-> wr_q)
		else $error("rx interrupt fell without a write");
	chk_rx_enables: assert property (o_rx_irq |-> en_q[0] && (en_q[14] || en_q[11]))
		else $error("rx interrupt high while its enables are off");
	chk_duplex_write: assert property (!$stable(o_full_duplex) |-> wr_q)
		else $error("duplex mode changed without a write");
	chk_rdata_hold: assert property (!$stable(o_hrdata) |-> rd_q)
		else $error("read data changed without a read");
	chk_ready_high: assert property (o_hreadyout && o_hresp == mis_pkg::HRESP_OKAY)
		else $error("slave stalled or answered with an error");
	cov_tx_irq: cover property ($rose(o_tx_irq));
	cov_rx_irq: cover property ($rose(o_rx_irq));
	cov_duplex: cover property ($rose(o_full_duplex));
endmodule : mis_irq_top_checker

bind mis_irq_top mis_irq_top_checker mis_irq_top_checker_inst (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.i_tx_status_set(i_tx_status_set), .i_flow_ctrl_frame(i_flow_ctrl_frame),
	.i_rx_dma_err_resp(i_rx_dma_err_resp), .i_rx_receiving(i_rx_receiving),
	.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_full_duplex(o_full_duplex)
);

// File: sim/mis_irq_top_tb.sv
// Bench of the interrupt status summary: AHB-Lite master tasks and event model.
// Assumes a zero-wait slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module mis_irq_top_tb;
	localparam logic [11:0] ST = mis_pkg::STATUS_OFS;  // Status register
	localparam logic [11:0] EN = mis_pkg::ENABLE_OFS;  // Enable register
	localparam logic [11:0] CT = mis_pkg::CONTROL_OFS; // Control register
	logic        clk_sys = 1'h0;
	logic        rst_n   = 1'h0;
	logic        hsel    = 1'h0;
	logic [31:0] haddr   = 32'h0000_0000;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'h0;
	logic [31:0] hwdata  = 32'h0000_0000;
	logic [31:0] hrdata, rd;
	logic        hready, hresp, tx_irq, rx_irq, fdx, control_frame_received, err, rcv;
	logic [7:0]  tx_set;
	int          fails = 0;
	int          n_compared = 0;
	int          cyc = 0;
	always #12.5 clk_sys = ~clk_sys;
	mis_irq_top mis_irq_top_inst (
		.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(mis_pkg::HSIZE_WORD),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_tx_status_set(tx_set), .i_flow_ctrl_frame(control_frame_received),
		.i_rx_dma_err_resp(err), .i_rx_receiving(rcv), .o_tx_irq(tx_irq),
		.o_rx_irq(rx_irq), .o_full_duplex(fdx));
	mis_mac_model mis_mac_model_inst (.i_clk_sys(clk_sys), .o_tx_status_set(tx_set),
		.o_flow_ctrl_frame(control_frame_received), .o_rx_dma_err_resp(err), .o_rx_receiving(rcv));
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= {20'h00000, ofs};
		hwrite <= wr;
		do @(posedge clk_sys); while (hready !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'h1);
		rd = hrdata;
		check({31'h0, hresp}, {31'h0, mis_pkg::HRESP_OKAY});
	endtask : bus
	task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
		bus(1'h1, ofs, d);
	endtask : wr
	task automatic rdc(input logic [11:0] ofs, input logic [31:0] exp);
		bus(1'h0, ofs, 32'h0000_0000);
		check(rd, exp);
	endtask : rdc
	// Interrupt lines, looked at once the last edge has settled
	task automatic irqs(input logic t, input logic r);
		@(negedge clk_sys);
		check({30'h0, tx_irq, rx_irq}, {30'h0, t, r});
	endtask : irqs
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin : main
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
		rdc(ST, mis_pkg::STATUS_RST);
		rdc(EN, mis_pkg::ENABLE_RST);
		rdc(CT, mis_pkg::CONTROL_RST);
		wr(EN, 32'ha5a5_5a5a);
		rdc(EN, 32'ha5a5_5a5a);
		wr(12'h00c, 32'hffff_ffff);
		rdc(12'h00c, 32'h0000_0000);
		irqs(1'h0, 1'h0);
		$display("test registers done");
		// Each tx source enabled alone, master off then on, then cleared
		for (int i = 0; i < 8; i++) begin
			wr(EN, 32'h1 << (17 + i));
			mis_mac_model_inst.pulse(8'hff, 1'h0, 1'h0, 1'h0);
			rdc(ST, 32'h01ff_0000);
			irqs(1'h0, 1'h0);
			wr(EN, (32'h1 << (17 + i)) | 32'h0001_0000);
			irqs(1'h1, 1'h0);
			wr(ST, 32'h1 << (17 + i));
			rdc(ST, 32'h01fe_0000 & ~(32'h1 << (17 + i)));
			irqs(1'h0, 1'h0);
			wr(ST, 32'h01fe_0000);
			rdc(ST, 32'h0000_0000);
		end
		$display("test tx summary done");
		wr(EN, 32'h0000_0801);
		mis_mac_model_inst.pulse(8'h00, 1'h1, 1'h0, 1'h0);
		rdc(ST, 32'h0000_0000);
		wr(CT, 32'h0000_0001);
		@(negedge clk_sys);
		check({31'h0, fdx}, 32'h0000_0001);
		mis_mac_model_inst.pulse(8'h00, 1'h1, 1'h0, 1'h0);
		rdc(ST, 32'h0000_4000);
		irqs(1'h0, 1'h0);
		wr(EN, 32'h0000_4801);
		rdc(ST, 32'h0000_4001);
		irqs(1'h0, 1'h1);
		wr(ST, 32'h0000_4000);
		rdc(ST, 32'h0000_0000);
		irqs(1'h0, 1'h0);
		$display("test control frame done");
		mis_mac_model_inst.pulse(8'h00, 1'h0, 1'h1, 1'h0);
		rdc(ST, 32'h0000_0000);
		mis_mac_model_inst.pulse(8'h00, 1'h0, 1'h1, 1'h1);
		rdc(ST, 32'h0000_0801);
		irqs(1'h0, 1'h1);
		wr(ST, 32'hffff_ffff);
		rdc(ST, 32'h0000_0000);
		irqs(1'h0, 1'h0);
		// After a bus error software resets the MAC
		mis_mac_model_inst.pulse(8'h00, 1'h0, 1'h1, 1'h1);
		rdc(ST, 32'h0000_0801);
		irqs(1'h0, 1'h1);
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
		rdc(ST, 32'h0000_0000);
		rdc(EN, 32'h0000_0000);
		@(negedge clk_sys);
		check({31'h0, fdx}, 32'h0000_0000);
		$display("test bus error done");
		tally_and_finish();
	end
endmodule : mis_irq_top_tb

// File: sim/mis_mac_model.sv
// Model of the MAC datapath and memory controller that raise status events.
// Assumes its task is called from the bench, one event burst at a time.
`timescale 1ns/1ps
module mis_mac_model (
	input  wire logic       i_clk_sys,         // System clock
	output logic      [7:0] o_tx_status_set,   // Tx event pulses
	output logic            o_flow_ctrl_frame, // Flow control frame seen
	output logic            o_rx_dma_err_resp, // ERROR reply from memory
	output logic            o_rx_receiving     // Reception in progress
);
	// Quiet lines from time zero
	initial begin
		o_tx_status_set   = 8'h00;
		o_flow_ctrl_frame = 1'h0;
		o_rx_dma_err_resp = 1'h0;
		o_rx_receiving    = 1'h0;
	end
	// One-cycle event burst, launched and retired on rising edges
	task automatic pulse(input logic [7:0] tx, input logic cf, input logic er, input logic rc);
		@(posedge i_clk_sys);
		o_tx_status_set   <= tx;
		o_flow_ctrl_frame <= cf;
		o_rx_dma_err_resp <= er;
		o_rx_receiving    <= rc;
		@(posedge i_clk_sys);
		o_tx_status_set   <= 8'h00;
		o_flow_ctrl_frame <= 1'h0;
		o_rx_dma_err_resp <= 1'h0;
		o_rx_receiving    <= 1'h0;
	endtask : pulse
endmodule : mis_mac_model
